// File: rtl/pic_cmd.sv
// pic_cmd: command interpreter for port input threshold, schmitt and read
// assumes rx bytes arrive in order from the network side, one per strobe,
// and tx bytes are taken by the network side at each edge where tx.valid and tx_ready are both high
//
// Operation
// - a threshold write for port b or c is '#', the port letter, then a select byte, 0=2.5V 1=1.4V.
// - every threshold select register powers up at 255, giving 1.4V on every line.
// - a schmitt write for port a, b or c is '$', the port letter, then an enable byte, 0 means on.
// - every schmitt enable register powers up at 255, all schmitt triggers off.
// - a schmitt write replaces all eight bits at once and only acts on input lines.
// - a port read is one lower-case letter, answered by the upper-case letter and a value byte.
// - a port read samples all eight pins of the port at one instant.
// - output lines are reported at their pin level, never from the output latch.
// - direction bit 0 is output, 1 is input, and all lines power up as inputs.
// - port a threshold uses the same three-byte form and encoding as ports b and c.
`timescale 1ns/1ps
`default_nettype none
module pic_cmd
  import pic_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // command stream in
  input  wire pic_byte_s            rx,
  output logic                      rx_ready,
  // reply stream out
  output pic_byte_s                 tx,
  input  wire logic                 tx_ready,
  // pins and direction from the port block
  input  wire logic [NUM_PORTS*8-1:0] pin_in,
  input  wire logic [NUM_PORTS*8-1:0] port_dir,
  // effective input configuration toward the pad cells
  output logic [NUM_PORTS*8-1:0]    thresh_sel,
  output logic [NUM_PORTS*8-1:0]    schmitt_en
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // map an upper-case port letter to an index, PORT_NONE if not a port
  function automatic logic [1:0] port_of(input logic [7:0] ch);
    if (ch >= CH_UP_A && ch <= CH_UP_C)
      port_of = 2'(ch - CH_UP_A);
    else
      port_of = PORT_NONE;
  endfunction : port_of

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  // pins are asynchronous; nothing but pin_sync reads pin_meta
  logic [NUM_PORTS*8-1:0] pin_meta;
  logic [NUM_PORTS*8-1:0] pin_sync;

  always_ff @(posedge ref_clk)
  begin
    pin_meta <= pin_in;
    pin_sync <= pin_meta;
  end

  // ---------------------------------------------------------------
  // decoder state
  // ---------------------------------------------------------------
  pic_state_e state;
  pic_state_e next_state;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [1:0] port;
  logic [1:0] next_port;
  logic [7:0] reply;
  logic [7:0] next_reply;
  pic_byte_s  next_tx;
  logic       next_rx_ready;
  pic_cfg_s   cfg      [NUM_PORTS];
  pic_cfg_s   next_cfg [NUM_PORTS];

  always_comb
  begin
    next_state    = state;
    next_cmd      = cmd;
    next_port     = port;
    next_reply    = reply;
    next_tx       = tx;
    next_cfg      = cfg;
    next_rx_ready = 1'b0;
    case (state)
      PIC_IDLE:
      begin
        // one byte taken per handshake; reply states hold rx_ready low
        next_rx_ready = 1'b1;
        if (rx.valid && rx_ready)
        begin
          next_rx_ready = 1'b0;
          if (rx.data == CH_THRESH || rx.data == CH_SCHMITT)
          begin
            next_cmd   = rx.data;
            next_state = PIC_CODE;
          end
          else if (rx.data >= CH_LO_A && rx.data <= CH_LO_C)
          begin
            // whole port captured in one cycle from pins
            next_port  = port_of(rx.data & ~CASE_BIT);
            next_reply = pin_sync[next_port*8 +: 8];
            next_tx    = '{valid: 1'b1, data: rx.data & ~CASE_BIT};
            next_state = PIC_REPLY_HI;
          end
        end
      end
      PIC_CODE:
      begin
        next_rx_ready = 1'b1;
        if (rx.valid && rx_ready)
        begin
          next_rx_ready = 1'b0;
          next_port     = port_of(rx.data);
          // unknown port letter drops the message
          if (next_port == PORT_NONE)
            next_state = PIC_IDLE;
          else
          begin
            // ready stays up so the data byte can follow at once
            next_state    = PIC_DATA;
            next_rx_ready = 1'b1;
          end
        end
      end
      PIC_DATA:
      begin
        next_rx_ready = 1'b1;
        if (rx.valid && rx_ready)
        begin
          next_rx_ready = 1'b0;
          // full byte replaces the register, no per-bit update
          if (cmd == CH_THRESH)
            next_cfg[port].thresh = rx.data;
          else
            next_cfg[port].schmitt = rx.data;
          next_state = PIC_IDLE;
        end
      end
      PIC_REPLY_HI:
        if (tx_ready)
        begin
          next_tx    = '{valid: 1'b1, data: reply};
          next_state = PIC_REPLY_LO;
        end
      PIC_REPLY_LO:
        if (tx_ready)
        begin
          next_tx    = '{valid: 1'b0, data: ZERO_BYTE};
          next_state = PIC_IDLE;
        end
      default:
        next_state = PIC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state    <= PIC_IDLE;
      cmd      <= ZERO_BYTE;
      port     <= 2'h0;
      reply    <= ZERO_BYTE;
      tx       <= '{valid: 1'b0, data: ZERO_BYTE};
      rx_ready <= 1'b0;
      for (int i = 0; i < NUM_PORTS; i++)
        cfg[i] <= '{thresh: THRESH_RST, schmitt: SCHMITT_RST};
    end
    else
    begin
      state    <= next_state;
      cmd      <= next_cmd;
      port     <= next_port;
      reply    <= next_reply;
      tx       <= next_tx;
      rx_ready <= next_rx_ready;
      cfg      <= next_cfg;
    end
  end

  // ---------------------------------------------------------------
  // pad configuration
  // ---------------------------------------------------------------
  // output lines get the reset value so pads see no stray schmitt/threshold
  // setting; the stored register keeps what the host wrote, so a line turned
  // back into an input gets its setting again without a new write
  wire logic [NUM_PORTS*8-1:0] next_thresh_sel;
  wire logic [NUM_PORTS*8-1:0] next_schmitt_en;
  genvar g;

  generate
    for (g = 0; g < NUM_PORTS; g++)
    begin : g_pad
      // direction 1 means input; only inputs take the setting
      assign next_thresh_sel[g*8 +: 8] = (cfg[g].thresh & port_dir[g*8 +: 8])
                                         | (THRESH_RST & ~port_dir[g*8 +: 8]);
      assign next_schmitt_en[g*8 +: 8] = (cfg[g].schmitt & port_dir[g*8 +: 8])
                                         | (SCHMITT_RST & ~port_dir[g*8 +: 8]);
    end
  endgenerate

  // registered so the pad controls stay glitch free while direction changes
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      thresh_sel <= {NUM_PORTS{THRESH_RST}};
      schmitt_en <= {NUM_PORTS{SCHMITT_RST}};
    end
    else
    begin
      thresh_sel <= next_thresh_sel;
      schmitt_en <= next_schmitt_en;
    end
  end

endmodule : pic_cmd
`default_nettype wire

// File: rtl/pic_pkg.sv
// pic_pkg: constants and carriers for the port input config command decoder
// assumes one 100 MHz clock and a byte-wide command stream from the host side
package pic_pkg;

  // ---------------------------------------------------------------
  // command characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_THRESH  = 8'h23;
  localparam logic [7:0] CH_SCHMITT = 8'h24;
  localparam logic [7:0] CH_UP_A    = 8'h41;
  localparam logic [7:0] CH_UP_C    = 8'h43;
  localparam logic [7:0] CH_LO_A    = 8'h61;
  localparam logic [7:0] CH_LO_C    = 8'h63;
  localparam logic [7:0] CASE_BIT   = 8'h20;

  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int         NUM_PORTS   = 3;
  localparam logic [7:0] THRESH_RST  = 8'hff;
  localparam logic [7:0] SCHMITT_RST = 8'hff;
  localparam logic [7:0] DIR_RST     = 8'hff;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [1:0] PORT_NONE   = 2'h3;

  typedef enum {PIC_IDLE, PIC_CODE, PIC_DATA, PIC_REPLY_HI, PIC_REPLY_LO} pic_state_e;

  // one byte with its strobe
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } pic_byte_s;

  // per-port input configuration
  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] schmitt;
  } pic_cfg_s;

endpackage : pic_pkg

// File: bench/pic_cmd_props.sv
// pic_cmd_props: port timing checks on the command decoder
// assumes one clock domain and the pic_pkg carriers
`timescale 1ns/1ps
`default_nettype none
module pic_cmd_props
  import pic_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire pic_byte_s   rx,
  input wire logic        rx_ready,
  input wire pic_byte_s   tx,
  input wire logic        tx_ready,
  input wire logic [23:0] pin_in,
  input wire logic [23:0] port_dir,
  input wire logic [23:0] thresh_sel,
  input wire logic [23:0] schmitt_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // message step as the stream shows it: 0 idle, 1 after a code, 2 after a port letter;
  // the decoder keeps ready up after a good letter so the data byte can follow at once
  logic       letter_ok;
  logic [1:0] phase;
  assign letter_ok = (rx.data >= CH_UP_A) && (rx.data <= CH_UP_C);
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      phase <= 2'h0;
    else if (rx.valid && rx_ready)
    begin
      if (phase == 2'h1 && letter_ok)
        phase <= 2'h2;
      else if (phase == 2'h0 && (rx.data == CH_THRESH || rx.data == CH_SCHMITT))
        phase <= 2'h1;
      else
        phase <= 2'h0;
    end
  end
  rst_out_a: assert property ($past(rst) |-> &{thresh_sel, schmitt_en} && !tx.valid)
    else $error("outputs not at reset value");
  take_drop_a: assert property (
    rx.valid && rx_ready && !(phase == 2'h1 && letter_ok) |=> !rx_ready)
    else $error("ready held after a byte that ends a step");
  letter_keep_a: assert property (
    rx.valid && rx_ready && phase == 2'h1 && letter_ok |=> rx_ready)
    else $error("ready dropped between port letter and data byte");
  busy_reply_a: assert property (tx.valid |-> !rx_ready)
    else $error("ready during a reply");
  reply_hold_a: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
    else $error("reply byte not held");
  reply_letter_a: assert property ($rose(tx.valid) |-> tx.data inside {[CH_UP_A:CH_UP_C]})
    else $error("reply does not open with a port letter");
  reply_end_a: assert property ($fell(tx.valid) |-> $past(tx_ready))
    else $error("reply dropped before taken");
  // output lines must never show a setting
  out_forced_a: assert property ((~$past(port_dir) & ~(thresh_sel & schmitt_en)) == 24'h0)
    else $error("output line shows a setting");
  thresh_cause_a: assert property (
    $changed(thresh_sel) && $past(port_dir) == $past(port_dir, 2)
    |-> $past(rx.valid && rx_ready, 2))
    else $error("threshold changed without a data byte");
  schmitt_cause_a: assert property (
    $changed(schmitt_en) && $past(port_dir) == $past(port_dir, 2)
    |-> $past(rx.valid && rx_ready, 2))
    else $error("schmitt enable changed without a data byte");
endmodule : pic_cmd_props
bind pic_cmd pic_cmd_props u_props (.ref_clk, .rst, .rx, .rx_ready, .tx, .tx_ready,
  .pin_in, .port_dir, .thresh_sel, .schmitt_en);
`default_nettype wire

// File: bench/pic_host.sv
// pic_host: network side taking reply bytes, optionally stalling
// assumes tx holds each byte until tx_ready is seen at an edge
`timescale 1ns/1ps
`default_nettype none
module pic_host
  import pic_pkg::*;
(
  input wire logic      ref_clk,
  input wire logic      slow,
  input wire pic_byte_s tx,
  output logic          tx_ready
);
  // slow takes every other cycle, so held bytes are exercised
  initial
  begin
    tx_ready = 1'b1;
    forever @(posedge ref_clk) tx_ready <= #1 slow ? !tx_ready : 1'b1;
  end
endmodule : pic_host
`default_nettype wire

// File: bench/tb_pic_cmd.sv
// tb_pic_cmd: directed command sequences with expected port values
// assumes pic_host takes replies and the checker is bound to the design
`timescale 1ns/1ps
`default_nettype none
module tb_pic_cmd
  import pic_pkg::*;
;
  logic        ref_clk, rst, rx_ready, tx_ready, slow;
  pic_byte_s   rx, tx;
  logic [23:0] pin_in, port_dir, thresh_sel, schmitt_en;
  logic [7:0]  q[$];
  int          num_errors, n_checks, p;
  pic_cmd DUT (.ref_clk, .rst, .rx, .rx_ready, .tx, .tx_ready, .pin_in, .port_dir,
    .thresh_sel, .schmitt_en);
  pic_host u_host (.ref_clk, .slow, .tx, .tx_ready);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (tx.valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx.data);
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic send(input logic [7:0] b);
    int i;
    @(posedge ref_clk) #1 rx = {1'b1, b};
    for (i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      if (rx_ready === 1'b1) break;
    end
    if (i == 40)
    begin
      chk("rx_ready", 24'h1, 24'h0);
      give_verdict();
    end
    else
      #1 rx.valid = 1'b0;
  endtask : send
  task automatic wr(input logic [7:0] c, input int pt, input logic [7:0] d);
    send(c);
    send(CH_UP_A + 8'(pt));
    send(d);
  endtask : wr
  task automatic idle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic rd(input int pt, input logic [7:0] v);
    int i;
    q.delete();
    send(CH_LO_A + 8'(pt));
    for (i = 0; i < 40 && q.size() < 2; i++) @(posedge ref_clk);
    chk("reply_len", 24'h2, 24'(q.size()));
    if (q.size() < 2)
      give_verdict();
    else
      chk("reply", {CH_UP_A + 8'(pt), v}, {q[0], q[1]});
  endtask : rd
  initial
  begin
    rx = '0;
    rst = 1'b1;
    slow = 1'b0;
    pin_in = 24'h0;
    port_dir = '1;
    num_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("thresh_sel", 24'hffffff, thresh_sel);
    chk("schmitt_en", 24'hffffff, schmitt_en);
    for (p = 0; p < 3; p++)
    begin
      wr(CH_THRESH, p, 8'h0f + 8'(p));
      wr(CH_SCHMITT, p, 8'hf0 - 8'(p));
    end
    idle();
    chk("thresh_sel", 24'h11100f, thresh_sel);
    chk("schmitt_en", 24'heeeff0, schmitt_en);
    port_dir = 24'hff00ff;
    wr(CH_THRESH, 3, 8'h00);
    wr(CH_SCHMITT, 0, 8'hf1);
    idle();
    chk("thresh_sel", 24'h11ff0f, thresh_sel);
    chk("schmitt_en", 24'heefff1, schmitt_en);
    pin_in = 24'h5aa533;
    slow = 1'b1;
    idle();
    rd(0, 8'h33);
    rd(1, 8'ha5);
    rd(2, 8'h5a);
    // lines turned back into inputs take their stored settings again
    #1 port_dir = '1;
    idle();
    chk("thresh_sel", 24'h11100f, thresh_sel);
    chk("schmitt_en", 24'heeeff1, schmitt_en);
    // second reset in mid-run, held two edges like the first
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("thresh_sel", 24'hffffff, thresh_sel);
    chk("schmitt_en", 24'hffffff, schmitt_en);
    rd(1, 8'ha5);
    give_verdict();
  end
endmodule : tb_pic_cmd
`default_nettype wire
